// *** rtl/trig_ctrl.v ***
// Two-channel trigger state machine with an APB register slave
//
// Overview of operation
// - Abort sends channel in any state to idle if continuous off
// - Abort with continuous on re-arms at once
// - Pending flag set outside idle, clear inside
// - Arming never blocks further command execution
// - Continuous off: one cycle, then back idle
// - Continuous on: cycles repeat, never idle
// - Continuous cleared by reset, set by preset
// - Continuous reads back 1 or 0
// - Single arm waits; trigger measures and stores
// - Bad single arm ignored, error -213
// - Auto delay settles before measuring; resets on
// - Trigger-now triggers a waiting channel
// - Trigger-now when not waiting: error -211
// - Bus source takes group, common, now triggers
// - Hold source takes only trigger-now
// - Immediate source: trigger always true
// - Source immediate on reset, power-up, local
// - Configure forces immediate source
// - Source change alone never arms; preset and local arm
// - Source reads back as one of three codes
// - Suffix 0 or 1 is A, 2 is B, 3 is error
// - Reset leaves idle; preset leaves waiting
`timescale 1ns/1ps
`include "trig_ctrl_map.vh"

module trig_ctrl #(
    parameter TWO_CHANNEL  = 1,
    parameter SETTLE_CYC   = `CYC_FROM_NS(`SETTLE_NS),
    parameter MEASURE_CYC  = `CYC_FROM_NS(`MEASURE_NS),
    parameter CNT_W        = 16
) (
    // Clock, reset, enable
    input  wire        clk_in,
    input  wire        rst_b_in,
    input  wire        clk_en_in,
    // APB slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    // Group execute trigger pin, asynchronous
    input  wire        group_trig_in,
    // Measurement strobes and status
    output reg  [1:0]  store_out,
    output reg  [1:0]  pending_out
);

    // ============================================================
    // States
    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_WAIT   = 2'h1;
    localparam [1:0] ST_SETTLE = 2'h2;
    localparam [1:0] ST_MEAS   = 2'h3;

    // ============================================================
    // Counter load values, cut to the counter width on purpose.
    // A count wider than CNT_W would wrap; keep the parameters small.
    localparam [31:0]      SETTLE_W   = SETTLE_CYC;
    localparam [31:0]      MEASURE_W  = MEASURE_CYC;
    localparam [CNT_W-1:0] SETTLE_LD  = SETTLE_W[CNT_W-1:0];
    localparam [CNT_W-1:0] MEASURE_LD = MEASURE_W[CNT_W-1:0];

    // ============================================================
    // Functions
    function trig_ok;
        input [1:0] src;
        input       now;
        input       bus_evt;
        begin
            case (src)
                `SRC_IMM:  trig_ok = 1'b1;
                `SRC_BUS:  trig_ok = now | bus_evt;
                `SRC_HOLD: trig_ok = now;
                default:   trig_ok = now;
            endcase
        end
    endfunction

    function [31:0] cfg_word;
        input       cont;
        input       dly;
        input [1:0] src;
        begin
            cfg_word = 32'h0000_0000;
            cfg_word[`CFG_CONT_BIT] = cont;
            cfg_word[`CFG_DELAY_BIT] = dly;
            cfg_word[`CFG_SRC_MSB:`CFG_SRC_LSB] = src;
        end
    endfunction

    // ============================================================
    // Group trigger synchroniser and edge detect
    reg         gt_meta_r;
    reg         gt_sync_r;
    reg         gt_prev_r;
    wire        gt_edge;

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gt_meta_r <= 1'b0;
            gt_sync_r <= 1'b0;
            gt_prev_r <= 1'b0;
        end else if (clk_en_in) begin
            gt_meta_r <= group_trig_in;
            gt_sync_r <= gt_meta_r;
            gt_prev_r <= gt_sync_r;
        end
    end

    assign gt_edge = gt_sync_r & ~gt_prev_r;

    // ============================================================
    // APB decode; every access answers in its second access cycle
    wire        acc    = psel_in & penable_in & ~pready_out;
    wire        wr     = acc & pwrite_in;
    wire        rd     = acc & ~pwrite_in;
    wire        cmd_wr = wr & (paddr_in == `REG_CMD);
    wire [3:0]  op     = pwdata_in[`CMD_OP_MSB:`CMD_OP_LSB];
    wire [1:0]  sfx    = pwdata_in[`CMD_SUFFIX_MSB:`CMD_SUFFIX_LSB];
    wire        sfx_bad;
    wire [1:0]  sel;
    wire        mapped;

    // Suffix 0 defaults to channel A
    assign sfx_bad = (sfx == 2'h3) ||
                     ((sfx == 2'h2) && (TWO_CHANNEL == 0));
    assign sel = sfx_bad ? 2'b00 :
                 (sfx == 2'h2) ? 2'b10 : 2'b01;
    assign mapped = (paddr_in == `REG_CMD)    ||
                    (paddr_in == `REG_CFG_A)  ||
                    ((paddr_in == `REG_CFG_B) && (TWO_CHANNEL != 0)) ||
                    (paddr_in == `REG_STATUS) ||
                    (paddr_in == `REG_ERROR)  ||
                    (paddr_in == `REG_MEAS_CNT);

    wire glob_reset  = cmd_wr & (op == `OP_COMMON_RESET);
    wire glob_preset = cmd_wr & ((op == `OP_PRESET) |
                                 (op == `OP_LOCAL_MODE));
    wire common_trig = cmd_wr & (op == `OP_COMMON_TRIG);
    wire bus_trig    = common_trig | gt_edge |
                       (cmd_wr & (op == `OP_GROUP_TRIG));

    // ============================================================
    // Per-channel state
    reg  [1:0]       st_r     [0:1];
    reg              cont_r   [0:1];
    reg              dly_r    [0:1];
    reg  [1:0]       src_r    [0:1];
    reg  [CNT_W-1:0] cnt_r    [0:1];
    reg  [15:0]      meas_r   [0:1];
    reg  [15:0]      err_r;
    reg              err_set;
    reg  [15:0]      err_nxt;

    // Error detection; last error reported wins
    integer k;
    always @* begin
        err_set = 1'b0;
        err_nxt = `ERR_NONE;
        if (cmd_wr && (op != `OP_NONE) && (op != `OP_COMMON_TRIG) &&
            (op != `OP_GROUP_TRIG) && (op != `OP_COMMON_RESET) &&
            (op != `OP_PRESET) && (op != `OP_LOCAL_MODE)) begin
            if (sfx_bad) begin
                err_set = 1'b1;
                err_nxt = `ERR_SUFFIX_RANGE;
            end else begin
                for (k = 0; k < 2; k = k + 1) begin
                    if (sel[k] && (op == `OP_SINGLE_ARM) &&
                        ((st_r[k] != ST_IDLE) || cont_r[k])) begin
                        err_set = 1'b1;
                        err_nxt = `ERR_INIT_IGNORED;
                    end
                    if (sel[k] && (op == `OP_TRIG_NOW) &&
                        (st_r[k] != ST_WAIT)) begin
                        err_set = 1'b1;
                        err_nxt = `ERR_TRIG_IGNORED;
                    end
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            wire here   = cmd_wr & sel[g];
            wire abort  = here & (op == `OP_ABORT);
            wire arm    = here & (op == `OP_SINGLE_ARM);
            wire now    = here & (op == `OP_TRIG_NOW);
            wire cfgop  = here & (op == `OP_CONFIGURE);
            wire cfg_wr = wr & (paddr_in == (g == 0 ? `REG_CFG_A
                                                    : `REG_CFG_B));
            wire live   = (g == 0) || (TWO_CHANNEL != 0);
            wire fire   = trig_ok(src_r[g], now, bus_trig);

            always @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    // Power-up: continuous on, waiting
                    st_r[g]   <= ST_WAIT;
                    cont_r[g] <= `CFG_RESET_CONT;
                    dly_r[g]  <= `CFG_RESET_DELAY;
                    src_r[g]  <= `SRC_IMM;
                    cnt_r[g]  <= {CNT_W{1'b0}};
                    meas_r[g] <= 16'h0000;
                end else if (clk_en_in && !live) begin
                    st_r[g]   <= ST_IDLE;
                    cont_r[g] <= 1'b0;
                end else if (clk_en_in) begin
                    if (glob_reset) begin
                        cont_r[g] <= 1'b0;
                        dly_r[g]  <= `CFG_RESET_DELAY;
                        src_r[g]  <= `SRC_IMM;
                        st_r[g]   <= ST_IDLE;
                    end else if (glob_preset) begin
                        cont_r[g] <= 1'b1;
                        dly_r[g]  <= `CFG_RESET_DELAY;
                        src_r[g]  <= `SRC_IMM;
                        st_r[g]   <= ST_WAIT;
                    end else if (cfg_wr) begin
                        // Only records settings; a newly set continuous
                        // flag leaves idle as the continuous mode says
                        cont_r[g] <= pwdata_in[`CFG_CONT_BIT];
                        dly_r[g]  <= pwdata_in[`CFG_DELAY_BIT];
                        src_r[g]  <= (pwdata_in[`CFG_SRC_MSB:`CFG_SRC_LSB]
                                      == 2'h3) ? src_r[g]
                                   : pwdata_in[`CFG_SRC_MSB:`CFG_SRC_LSB];
                        if (st_r[g] == ST_IDLE &&
                            pwdata_in[`CFG_CONT_BIT])
                            st_r[g] <= ST_WAIT;
                    end else if (abort) begin
                        // Settings untouched, only the state moves
                        st_r[g] <= cont_r[g] ? ST_WAIT
                                             : ST_IDLE;
                    end else begin
                        if (cfgop)
                            src_r[g] <= `SRC_IMM;
                        case (st_r[g])
                            ST_IDLE: begin
                                if (arm && !cont_r[g])
                                    st_r[g] <= ST_WAIT;
                            end
                            ST_WAIT: begin
                                if (fire && dly_r[g]) begin
                                    st_r[g]  <= ST_SETTLE;
                                    cnt_r[g] <= SETTLE_LD;
                                end else if (fire) begin
                                    st_r[g]  <= ST_MEAS;
                                    cnt_r[g] <= MEASURE_LD;
                                end
                            end
                            ST_SETTLE: begin
                                if (cnt_r[g] <= 1) begin
                                    st_r[g]  <= ST_MEAS;
                                    cnt_r[g] <= MEASURE_LD;
                                end else begin
                                    cnt_r[g] <= cnt_r[g] - 1'b1;
                                end
                            end
                            ST_MEAS: begin
                                if (cnt_r[g] <= 1) begin
                                    meas_r[g] <= meas_r[g] + 1'b1;
                                    st_r[g]   <= cont_r[g] ? ST_WAIT
                                               : ST_IDLE;
                                end else begin
                                    cnt_r[g] <= cnt_r[g] - 1'b1;
                                end
                            end
                            default: st_r[g] <= ST_IDLE;
                        endcase
                    end
                end
            end

            // Store strobe and pending flag, registered outputs
            always @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    store_out[g]   <= 1'b0;
                    pending_out[g] <= 1'b0;
                end else if (clk_en_in) begin
                    store_out[g] <= (st_r[g] == ST_MEAS) &&
                                    (cnt_r[g] <= 1) && !glob_reset &&
                                    !glob_preset && !cfg_wr && !abort;
                    pending_out[g] <= (st_r[g] != ST_IDLE);
                end
            end
        end
    endgenerate

    // ============================================================
    // Error register; a new error wins over the read-to-clear
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            err_r <= `ERR_NONE;
        end else if (clk_en_in) begin
            if (err_set)
                err_r <= err_nxt;
            else if (rd && paddr_in == `REG_ERROR)
                err_r <= `ERR_NONE;
        end
    end

    // ============================================================
    // APB answer, one wait cycle per access; commands never stall
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else if (clk_en_in) begin
            pready_out  <= acc;
            pslverr_out <= acc & ~mapped;
            prdata_out  <= 32'h0000_0000;
            if (rd) begin
                case (paddr_in)
                    `REG_CFG_A:
                        prdata_out <= cfg_word(cont_r[0], dly_r[0],
                                               src_r[0]);
                    `REG_CFG_B:
                        prdata_out <= cfg_word(cont_r[1], dly_r[1],
                                               src_r[1]);
                    `REG_STATUS:
                        prdata_out <= {24'h000000, st_r[1], st_r[0],
                                       2'h0, pending_out};
                    `REG_ERROR:
                        prdata_out <= {16'h0000, err_r};
                    `REG_MEAS_CNT:
                        prdata_out <= {meas_r[1], meas_r[0]};
                    default:
                        prdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// *** rtl/trig_ctrl_map.vh ***
// Register map, field codes and timing constants of the trigger controller
`ifndef TRIG_CTRL_MAP_VH
`define TRIG_CTRL_MAP_VH

// ============================================================
// Register byte addresses
`define REG_CMD          12'h000
`define REG_CFG_A        12'h004
`define REG_CFG_B        12'h008
`define REG_STATUS       12'h00c
`define REG_ERROR        12'h010
`define REG_MEAS_CNT     12'h014

// ============================================================
// Command register fields
`define CMD_OP_LSB       0
`define CMD_OP_MSB       3
`define CMD_SUFFIX_LSB   4
`define CMD_SUFFIX_MSB   5

`define OP_NONE          4'h0
`define OP_ABORT         4'h1
`define OP_SINGLE_ARM    4'h2
`define OP_TRIG_NOW      4'h3
`define OP_COMMON_TRIG   4'h4
`define OP_GROUP_TRIG    4'h5
`define OP_COMMON_RESET  4'h6
`define OP_PRESET        4'h7
`define OP_LOCAL_MODE    4'h8
`define OP_CONFIGURE     4'h9

// ============================================================
// Channel config fields: continuous, auto delay, source
`define CFG_CONT_BIT     0
`define CFG_DELAY_BIT    1
`define CFG_SRC_LSB      2
`define CFG_SRC_MSB      3

`define SRC_IMM          2'h0
`define SRC_BUS          2'h1
`define SRC_HOLD         2'h2

// Power-up and preset values
`define CFG_RESET_CONT   1'h1
`define CFG_RESET_DELAY  1'h1

// ============================================================
// Error codes, two's complement in 16 bits
`define ERR_NONE         16'h0000
`define ERR_TRIG_IGNORED 16'hff2d
`define ERR_INIT_IGNORED 16'hff2b
`define ERR_SUFFIX_RANGE 16'hff72

// ============================================================
// Timing
`define CLK_PERIOD_NS    50
`define SETTLE_NS        1000
`define MEASURE_NS       200
`define CYC_FROM_NS(t)   (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** test/host_apb.sv ***
// Host side model: APB master and group execute trigger line
`timescale 1ns/1ps

module host_apb (
    // Clock
    input  wire        clk_in,
    // APB master
    output reg         psel_out,
    output reg         penable_out,
    output reg         pwrite_out,
    output reg  [11:0] paddr_out,
    output reg  [31:0] pwdata_out,
    input  wire [31:0] prdata_in,
    input  wire        pready_in,
    // Bus trigger line
    output reg         group_trig_out
);
    initial begin
        psel_out       = 1'b0;
        penable_out    = 1'b0;
        pwrite_out     = 1'b0;
        paddr_out      = 12'h0;
        pwdata_out     = 32'h0;
        group_trig_out = 1'b0;
    end

    // ========================================
    // One transfer; starts a cycle after the last release
    task xfer(input w, input [11:0] a, input [31:0] d,
              output [31:0] q, output ok);
        integer n;
        begin
            ok = 1'b0;
            q  = 32'h0;
            @(posedge clk_in);
            psel_out    <= 1'b1;
            penable_out <= 1'b0;
            pwrite_out  <= w;
            paddr_out   <= a;
            pwdata_out  <= d;
            @(posedge clk_in);
            penable_out <= 1'b1;
            for (n = 0; n < 16 && !ok; n = n + 1) begin
                @(posedge clk_in);
                if (pready_in === 1'b1) begin
                    q  = prdata_in;
                    ok = 1'b1;
                end
            end
            psel_out    <= 1'b0;
            penable_out <= 1'b0;
            // Released lines must not keep showing the last value
            paddr_out   <= ~a;
            pwdata_out  <= ~d;
        end
    endtask

    // ========================================
    // Rising edge on the bus trigger line
    task pulse_trig;
        begin
            @(posedge clk_in);
            group_trig_out <= 1'b1;
            repeat (2) @(posedge clk_in);
            group_trig_out <= 1'b0;
        end
    endtask
endmodule

// *** test/trig_ctrl_sva.sv ***
// Port checker of the trigger controller
`timescale 1ns/1ps
`include "trig_ctrl_map.vh"

module trig_ctrl_sva (
    // Clock and reset
    input wire        clk_in,
    input wire        rst_b_in,
    input wire        clk_en_in,
    // APB
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        pslverr_out,
    // Trigger and status
    input wire        group_trig_in,
    input wire [1:0]  store_out,
    input wire [1:0]  pending_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // ========================================
    // Assertions
    chk_ready_after_take: assert property (
        psel_in && penable_in && !pready_out && clk_en_in |=> pready_out)
        else $error("pready missing after access");
    chk_ready_one_cycle: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    chk_ready_has_cause: assert property (
        pready_out |-> $past(psel_in && penable_in))
        else $error("pready without access");
    chk_slverr_unmapped: assert property (
        pready_out && paddr_in > `REG_MEAS_CNT |-> pslverr_out)
        else $error("unmapped address not refused");
    chk_slverr_mapped: assert property (
        pready_out && paddr_in <= `REG_MEAS_CNT && paddr_in[1:0] == 2'h0
        |-> !pslverr_out)
        else $error("mapped address refused");
    chk_cmd_reads_zero: assert property (
        pready_out && !pwrite_in && paddr_in == `REG_CMD
        |-> prdata_out == 32'h0)
        else $error("command register read not zero");
    chk_rdata_quiet: assert property (
        !pready_out |-> prdata_out == 32'h0)
        else $error("read data outside answer");
    chk_store_pulse: assert property (
        store_out != 2'h0 |=> (store_out & $past(store_out)) == 2'h0)
        else $error("store strobe longer than one cycle");

    cover property (pready_out && pslverr_out);
    cover property (store_out[0]);
    cover property (store_out[1]);
endmodule

bind trig_ctrl trig_ctrl_sva i_trig_ctrl_sva (.*);

// *** test/tb.sv ***
// Self-checking bench of the trigger controller
`timescale 1ns/1ps
`include "trig_ctrl_map.vh"

module tb;
    localparam SETTLE = 2;
    reg         clk_in;
    reg         rst_b_in;
    wire        psel;
    wire        penable;
    wire        pwrite;
    wire        pready;
    wire        gtrig;
    wire [11:0] paddr;
    wire [31:0] pwdata;
    wire [31:0] prdata;
    wire [1:0]  store;
    wire [1:0]  pending;
    integer     n_errors;
    integer     comparisons;
    integer     lat0;
    integer     lat1;
    reg  [31:0] q;
    reg  [31:0] c0;

    trig_ctrl #(.TWO_CHANNEL(1), .SETTLE_CYC(SETTLE), .MEASURE_CYC(1))
    i_trig_ctrl (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(1'b1),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(), .group_trig_in(gtrig),
        .store_out(store), .pending_out(pending));

    host_apb i_host_apb (.clk_in(clk_in), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
        .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready),
        .group_trig_out(gtrig));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // ========================================
    // Helpers
    task close_out;
        begin
            $display("errors %0d comparisons %0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task chk(input [8*10-1:0] what, input [31:0] exp, input [31:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[ERR] %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task xf(input w, input [11:0] a, input [31:0] d);
        reg ok;
        begin
            i_host_apb.xfer(w, a, d, q, ok);
            if (!ok) begin
                chk("pready", 1, 0);
                close_out;
            end
        end
    endtask
    task wait_store(input integer ch, output integer n);
        begin
            // The strobe may rise at the edge on which the command returns
            n = 0;
            #1;
            while (store[ch] !== 1'b1) begin
                @(posedge clk_in);
                #1;
                n = n + 1;
                if (n > 200) begin
                    chk("store", 1, 0);
                    close_out;
                end
            end
        end
    endtask

    // ========================================
    // Scenarios
    task t_power_up;
        integer n;
        begin
            xf(0, `REG_CFG_A, 0);
            chk("cfg_a", 32'h3, q);
            xf(0, `REG_CFG_B, 0);
            chk("cfg_b", 32'h3, q);
            chk("pending", 3, pending);
            wait_store(0, n);
            wait_store(1, n);
            xf(1, `REG_CMD, 32'h6);
            xf(0, `REG_CFG_A, 0);
            chk("cfg_a", 32'h2, q);
            xf(0, `REG_STATUS, 0);
            chk("states", 0, q[7:4]);
            chk("pending", 0, pending);
        end
    endtask
    task t_hold_single;
        begin
            xf(1, `REG_CFG_A, 32'h8);
            xf(0, `REG_STATUS, 0);
            chk("state_a", 0, q[5:4]);
            xf(0, `REG_MEAS_CNT, 0);
            c0 = q;
            xf(1, `REG_CMD, 32'h12);
            xf(0, `REG_STATUS, 0);
            chk("state_a", 1, q[5:4]);
            chk("pending", 1, pending[0]);
            xf(1, `REG_CMD, 32'h4);
            xf(0, `REG_STATUS, 0);
            chk("state_a", 1, q[5:4]);
            xf(0, `REG_ERROR, 0);
            xf(1, `REG_CMD, 32'h12);
            xf(0, `REG_ERROR, 0);
            chk("error", `ERR_INIT_IGNORED, q[15:0]);
            xf(1, `REG_CMD, 32'h13);
            wait_store(0, lat0);
            xf(0, `REG_STATUS, 0);
            chk("state_a", 0, q[5:4]);
            xf(0, `REG_MEAS_CNT, 0);
            chk("meas_cnt", (c0 + 1) & 32'hffff, q[15:0]);
            xf(1, `REG_CMD, 32'h13);
            xf(0, `REG_ERROR, 0);
            chk("error", `ERR_TRIG_IGNORED, q[15:0]);
        end
    endtask
    task t_bus_delay;
        integer i;
        integer n;
        begin
            xf(1, `REG_CFG_B, 32'h6);
            xf(0, `REG_CFG_B, 0);
            chk("cfg_b", 32'h6, q);
            for (i = 3; i < 6; i = i + 1) begin
                xf(1, `REG_CMD, 32'h22);
                xf(1, `REG_CMD, 32'h20 | i);
                wait_store(1, n);
                if (i == 3)
                    chk("settle", lat0 + SETTLE, n);
            end
            xf(1, `REG_CMD, 32'h22);
            i_host_apb.pulse_trig;
            wait_store(1, n);
        end
    endtask
    task t_abort;
        begin
            xf(1, `REG_CFG_A, 32'h9);
            xf(0, `REG_STATUS, 0);
            chk("state_a", 1, q[5:4]);
            xf(1, `REG_CMD, 32'h11);
            xf(0, `REG_STATUS, 0);
            chk("state_a", 1, q[5:4]);
            xf(1, `REG_CFG_A, 32'h8);
            xf(1, `REG_CMD, 32'h11);
            xf(0, `REG_STATUS, 0);
            chk("state_a", 0, q[5:4]);
            xf(1, `REG_CMD, 32'h12);
            xf(0, `REG_STATUS, 0);
            chk("state_a", 1, q[5:4]);
            xf(0, `REG_CFG_A, 0);
            chk("cfg_a", 32'h8, q);
        end
    endtask
    task t_global;
        begin
            // Configure form only, so channel B falls back to immediate source
            xf(1, `REG_CMD, 32'h29);
            xf(0, `REG_CFG_B, 0);
            chk("src_b", 0, q[3:2]);
            xf(0, `REG_ERROR, 0);
            xf(1, `REG_CMD, 32'h31);
            xf(0, `REG_ERROR, 0);
            chk("error", `ERR_SUFFIX_RANGE, q[15:0]);
            xf(1, `REG_CMD, 32'h7);
            xf(0, `REG_CFG_A, 0);
            chk("cont_a", 1, q[0]);
            xf(0, `REG_STATUS, 0);
            chk("armed_a", 1, q[5:4] != 2'h0);
            xf(1, `REG_CFG_A, 32'h8);
            xf(1, `REG_CMD, 32'h8);
            xf(0, `REG_CFG_A, 0);
            chk("cfg_a", 32'h1, q & 32'hd);
            xf(0, 12'h020, 0);
            chk("unmapped", 0, q);
        end
    endtask

    initial begin
        n_errors    = 0;
        comparisons = 0;
        rst_b_in    = 1'b0;
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_power_up;
        t_hold_single;
        t_bus_delay;
        t_abort;
        t_global;
        close_out;
    end
endmodule
